// File: hdl/ccfm_pkg.sv
// Constants and types shared by the counter / compare / frequency block
package ccfm_pkg;
   localparam int          CLK_HZ_DEF    = 25_000_000;
   localparam int          MS_PER_S      = 1000;
   localparam int          ADDR_W        = 12;
   // Register byte addresses
   localparam logic [11:0] ADDR_CTRL     = 12'h300;
   localparam logic [11:0] ADDR_IRQEN    = 12'h304;
   localparam logic [11:0] ADDR_CMPVAL   = 12'h308;
   localparam logic [11:0] ADDR_PULSE    = 12'h30c;
   localparam logic [11:0] ADDR_INTEG    = 12'h310;
   localparam logic [11:0] ADDR_STATUS   = 12'h314;
   localparam logic [11:0] ADDR_ACK      = 12'h318;
   localparam logic [11:0] ADDR_CH0      = 12'h330;
   localparam logic [11:0] ADDR_CH1      = 12'h334;
   localparam logic [11:0] ADDR_CH2      = 12'h338;
   localparam logic [11:0] ADDR_CH3      = 12'h33c;
   // Control register field positions
   localparam int          CTRL_SWGATE   = 0;
   localparam int          CTRL_HWGEN    = 1;
   localparam int          CTRL_FREQ     = 2;
   localparam int          CTRL_OUTC_LO  = 3;
   localparam int          CTRL_MDIR_LO  = 5;
   localparam int          CTRL_SWOUT    = 7;
   localparam int          CTRL_FSEL_LO  = 8;
   localparam int          CTRL_ISEL_LO  = 11;
   // Interrupt enable / cause bit positions
   localparam int          EV_GOPEN      = 0;
   localparam int          EV_GCLOSE     = 1;
   localparam int          EV_CMP        = 2;
   localparam int          EV_OVF        = 3;
   localparam int          EV_UDF        = 4;
   localparam int          EV_MEAS       = 5;
   // Values after reset and limits
   localparam logic [2:0]  FSEL_RST      = 3'h5;
   localparam logic [13:0] INTEG_RST     = 14'h0064;
   localparam logic [13:0] INTEG_MIN     = 14'h000a;
   localparam logic [13:0] INTEG_MAX     = 14'h2710;
   localparam logic [7:0]  PULSE_RST     = 8'h00;
   localparam int          PULSE_STEP_MS = 2;
   localparam logic [31:0] CNT_MAX       = 32'h7fffffff;
   localparam logic [31:0] CNT_MIN       = 32'h80000000;

   typedef enum logic [1:0] {OC_NONE, OC_GE, OC_LE, OC_PULSE} ccfm_outc_t;
   typedef enum logic [1:0] {MD_NONE, MD_UP, MD_DOWN, MD_RSVD} ccfm_mdir_t;
   typedef enum logic [1:0] {IS_NONE, IS_PROC, IS_DIAG, IS_RSVD} ccfm_isel_t;

   // Half period in clocks of the selected input frequency limit
   function automatic logic [13:0] ccfm_filt_len(input logic [2:0] sel,
                                                 input int clkHz);
      int kHz;
      kHz = 60;
      unique case (sel)
         3'h0: kHz = 1;
         3'h1: kHz = 2;
         3'h2: kHz = 5;
         3'h3: kHz = 10;
         3'h4: kHz = 30;
         3'h5: kHz = 60;
         default: kHz = 100;
      endcase
      return 14'(clkHz / (2 * kHz * MS_PER_S));
   endfunction : ccfm_filt_len
endpackage : ccfm_pkg

// File: hdl/ccfm_top.sv
// Counter channel with compare output, input filters and frequency meter
`timescale 1ns/1ps
module ccfm_top #(
   parameter int CLK_HZ = ccfm_pkg::CLK_HZ_DEF
) (
   input  wire logic                        clk_sys,
   input  wire logic                        nrst,
   input  wire logic                        clkEn,
   input  wire logic [ccfm_pkg::ADDR_W-1:0] addr,
   input  wire logic [31:0]                 wrData,
   input  wire logic                        wrEn,
   input  wire logic                        rdEn,
   output logic      [31:0]                 rdData,
   input  wire logic [3:0]                  cntPulse,
   input  wire logic                        cntDir,
   input  wire logic                        extGateIn,
   output logic                             chanOut,
   output logic                             cmpStatusFlag,
   output logic                             procIrq,
   output logic                             diagIrq,
   output logic      [5:0]                  irqCause
);
   import ccfm_pkg::*;

   localparam int          MS_CYC = CLK_HZ / MS_PER_S;
   localparam logic [23:0] MS_TOP = 24'(MS_CYC - 1);

   typedef struct packed {
      logic [5:0]        lvl;
      logic [5:0][13:0]  fcnt;
      logic [23:0]       msDiv;
      logic [31:0]       cnt;
      logic              cmpStat;
      logic              outQ;
      logic              pulseOn;
      logic              pulseHold;
      logic [8:0]        pulseLeft;
      logic [13:0]       integMs;
      logic [3:0][31:0]  accum;
      logic [3:0][31:0]  freqVal;
      logic              swGate;
      logic              hwGateEn;
      logic              freqMode;
      ccfm_outc_t        outChar;
      ccfm_mdir_t        mainDir;
      logic              swOut;
      logic [2:0]        freqSel;
      ccfm_isel_t        irqSel;
      logic [5:0]        irqEn;
      logic [31:0]       cmpVal;
      logic [7:0]        pulseCfg;
      logic [13:0]       integCfg;
      logic              irqPend;
      logic              procIrq;
      logic              diagIrq;
      logic [5:0]        irqCause;
      logic [31:0]       rdData;
   } ccfm_state_t;

   function automatic ccfm_state_t ccfm_rst();
      ccfm_state_t r;
      r          = '0;
      r.freqSel  = FSEL_RST;
      r.integCfg = INTEG_RST;
      r.pulseCfg = PULSE_RST;
      return r;
   endfunction : ccfm_rst

   // Reset image as a constant, so the reset branch loads no logic
   localparam ccfm_state_t S_RST = ccfm_rst();

   logic [1:0]  rstSync_r;
   logic        rstN;
   ccfm_state_t s_r;
   ccfm_state_t s_nxt;

   ////////////////////////////////////////////////////////////////////////
   // Reset release
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rstSync_r <= 2'h0;
      end else begin
         rstSync_r <= {rstSync_r[0], 1'b1};
      end
   end
   assign rstN = rstSync_r[1];

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      logic [5:0]  rawIn;
      logic [5:0]  rise;
      logic [5:0]  fall;
      logic [5:0]  ev;
      logic [5:0]  evm;
      logic [13:0] flen;
      logic        msTick;
      logic        gateOpen;
      logic        step;
      logic        up;
      logic [31:0] cntNext;
      logic        reach;
      logic        ge;
      logic        le;
      logic        measEnd;
      logic        ack;
      logic [13:0] wInteg;
      s_nxt    = s_r;
      rawIn    = {extGateIn, cntDir, cntPulse};
      flen     = ccfm_filt_len(s_r.freqSel, CLK_HZ);
      ev       = '0;
      measEnd  = 1'b0;
      ack      = 1'b0;
      wInteg   = wrData[13:0];
      s_nxt.rdData  = '0;
      s_nxt.procIrq = 1'b0;
      s_nxt.diagIrq = 1'b0;

      // A level is accepted only after it has stood a half period
      for (int k = 0; k < 6; k++) begin
         if (rawIn[k] == s_r.lvl[k]) begin
            s_nxt.fcnt[k] = '0;
         end else if (s_r.fcnt[k] + 14'h0001 >= flen) begin
            s_nxt.lvl[k]  = rawIn[k];
            s_nxt.fcnt[k] = '0;
         end else begin
            s_nxt.fcnt[k] = s_r.fcnt[k] + 14'h0001;
         end
      end
      rise = s_nxt.lvl & ~s_r.lvl;
      fall = ~s_nxt.lvl & s_r.lvl;

      msTick = (s_r.msDiv >= MS_TOP);
      s_nxt.msDiv = msTick ? 24'h000000 : s_r.msDiv + 24'h000001;

      // Channel 3 gate and counter
      gateOpen = s_r.swGate & (~s_r.hwGateEn | s_r.lvl[5]);
      if (s_r.swGate && s_r.hwGateEn) begin
         ev[EV_GOPEN]  = rise[5];
         ev[EV_GCLOSE] = fall[5];
      end
      step    = rise[3] & gateOpen;
      up      = s_r.lvl[4];
      cntNext = up ? s_r.cnt + 32'h00000001 : s_r.cnt - 32'h00000001;
      if (step) begin
         s_nxt.cnt = cntNext;
      end
      ev[EV_OVF] = step & up & (s_r.cnt == CNT_MAX);
      ev[EV_UDF] = step & ~up & (s_r.cnt == CNT_MIN);
      reach = step && (cntNext == s_r.cmpVal) &&
              (s_r.mainDir == MD_NONE || s_r.mainDir == MD_RSVD ||
               (s_r.mainDir == MD_UP) == up);

      ge = $signed(s_r.cnt) >= $signed(s_r.cmpVal);
      le = $signed(s_r.cnt) <= $signed(s_r.cmpVal);
      unique case (s_r.outChar)
         OC_NONE: begin
            s_nxt.outQ    = s_r.swOut;
            s_nxt.cmpStat = 1'b0;
            s_nxt.pulseOn = 1'b0;
         end
         OC_GE: begin
            s_nxt.outQ    = ge;
            s_nxt.cmpStat = ge;
            s_nxt.pulseOn = 1'b0;
         end
         OC_LE: begin
            s_nxt.outQ    = le;
            s_nxt.cmpStat = le;
            s_nxt.pulseOn = 1'b0;
         end
         OC_PULSE: begin
            if (!s_r.pulseOn) begin
               if (reach) begin
                  s_nxt.pulseOn   = 1'b1;
                  s_nxt.pulseHold = (s_r.pulseCfg == 8'h00);
                  // Duration latched here, later writes wait
                  s_nxt.pulseLeft = {s_r.pulseCfg, 1'b0};
               end
            end else if (s_r.pulseHold) begin
               // New comparison value also ends a held pulse
               if (s_nxt.cnt != s_nxt.cmpVal) begin
                  s_nxt.pulseOn = 1'b0;
               end
            end else if (msTick) begin
               // Re-reaching the value is ignored while timing
               s_nxt.pulseLeft = s_r.pulseLeft - 9'h001;
               if (s_r.pulseLeft <= 9'h001) begin
                  s_nxt.pulseOn = 1'b0;
               end
            end
            s_nxt.outQ    = s_nxt.pulseOn;
            s_nxt.cmpStat = s_nxt.pulseOn;
         end
      endcase
      ev[EV_CMP] = s_nxt.cmpStat & ~s_r.cmpStat;

      // Frequency measurement over the integration time
      if (s_r.freqMode) begin
         for (int k = 0; k < 4; k++) begin
            if (rise[k] && s_r.swGate) begin
               s_nxt.accum[k] = s_r.accum[k] + 32'h00000001;
            end
         end
         if (msTick) begin
            s_nxt.integMs = s_r.integMs + 14'h0001;
            if (s_r.integMs + 14'h0001 >= s_r.integCfg) begin
               measEnd       = 1'b1;
               s_nxt.integMs = '0;
               s_nxt.freqVal = s_nxt.accum;
               s_nxt.accum   = '0;
            end
         end
      end else begin
         s_nxt.integMs = '0;
         s_nxt.accum   = '0;
      end
      ev[EV_MEAS] = measEnd;

      // Register writes
      if (wrEn) begin
         unique case (addr)
            ADDR_CTRL: begin
               s_nxt.swGate   = wrData[CTRL_SWGATE];
               s_nxt.hwGateEn = wrData[CTRL_HWGEN];
               s_nxt.freqMode = wrData[CTRL_FREQ];
               s_nxt.outChar  = ccfm_outc_t'(wrData[CTRL_OUTC_LO +: 2]);
               s_nxt.mainDir  = ccfm_mdir_t'(wrData[CTRL_MDIR_LO +: 2]);
               s_nxt.swOut    = wrData[CTRL_SWOUT];
               s_nxt.freqSel  = wrData[CTRL_FSEL_LO +: 3];
               s_nxt.irqSel   = ccfm_isel_t'(wrData[CTRL_ISEL_LO +: 2]);
               if (wrData[CTRL_OUTC_LO +: 2] != s_r.outChar) begin
                  s_nxt.pulseOn = 1'b0;
               end
            end
            ADDR_IRQEN:  s_nxt.irqEn    = wrData[5:0];
            ADDR_CMPVAL: s_nxt.cmpVal   = wrData;
            ADDR_PULSE:  s_nxt.pulseCfg = wrData[7:0];
            ADDR_INTEG: begin
               // Out of range writes are clamped to the limits
               if (wInteg < INTEG_MIN || wrData[31:14] != 18'h00000) begin
                  s_nxt.integCfg = (wrData[31:14] != 18'h00000) ?
                                   INTEG_MAX : INTEG_MIN;
               end else if (wInteg > INTEG_MAX) begin
                  s_nxt.integCfg = INTEG_MAX;
               end else begin
                  s_nxt.integCfg = wInteg;
               end
            end
            ADDR_ACK: ack = wrData[0];
            default: ;
         endcase
      end

      // Interrupt output; a new event beats a same-cycle acknowledge
      evm = ev & s_r.irqEn;
      if (s_r.irqSel != IS_NONE && evm != 6'h00) begin
         s_nxt.procIrq  = 1'b1;
         s_nxt.irqCause = evm;
         s_nxt.diagIrq  = s_r.irqPend && (s_r.irqSel == IS_DIAG);
      end
      s_nxt.irqPend = (s_r.irqPend & ~ack) |
                      (s_r.irqSel != IS_NONE && evm != 6'h00);

      // Register reads, data valid the next cycle only
      if (rdEn) begin
         unique case (addr)
            ADDR_CTRL: s_nxt.rdData = {19'h00000, s_r.irqSel, s_r.freqSel,
                                       s_r.swOut, s_r.mainDir, s_r.outChar,
                                       s_r.freqMode, s_r.hwGateEn,
                                       s_r.swGate};
            ADDR_IRQEN:  s_nxt.rdData = {26'h0000000, s_r.irqEn};
            ADDR_CMPVAL: s_nxt.rdData = s_r.cmpVal;
            ADDR_PULSE:  s_nxt.rdData = {24'h000000, s_r.pulseCfg};
            ADDR_INTEG:  s_nxt.rdData = {18'h00000, s_r.integCfg};
            ADDR_STATUS: s_nxt.rdData = {28'h0000000, gateOpen, s_r.irqPend,
                                         s_r.outQ, s_r.cmpStat};
            ADDR_CH0: s_nxt.rdData = s_r.freqMode ? s_r.freqVal[0] : '0;
            ADDR_CH1: s_nxt.rdData = s_r.freqMode ? s_r.freqVal[1] : '0;
            ADDR_CH2: s_nxt.rdData = s_r.freqMode ? s_r.freqVal[2] : '0;
            ADDR_CH3: s_nxt.rdData = s_r.freqMode ? s_r.freqVal[3]
                                                  : s_r.cnt;
            default: s_nxt.rdData = '0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         s_r <= S_RST;
      end else if (clkEn) begin
         s_r <= s_nxt;
      end
   end

   assign rdData        = s_r.rdData;
   assign chanOut       = s_r.outQ;
   assign cmpStatusFlag = s_r.cmpStat;
   assign procIrq       = s_r.procIrq;
   assign diagIrq       = s_r.diagIrq;
   assign irqCause      = s_r.irqCause;

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstN);

   property p_noCmp;
      (clkEn && s_r.outChar == OC_NONE && !wrEn)
         |=> (!cmpStatusFlag && chanOut == $past(s_r.swOut));
   endproperty
   a_noCmp: assert property (p_noCmp)
      else $error("compare flag set with no comparison");

   property p_geOut;
      (clkEn && !wrEn && s_r.outChar == OC_GE)
         |=> (chanOut == ($signed($past(s_r.cnt)) >=
                          $signed($past(s_r.cmpVal))));
   endproperty
   a_geOut: assert property (p_geOut)
      else $error("comparator output wrong");

   property p_pulseLen;
      ($rose(s_r.pulseOn) && !s_r.pulseHold)
         |-> (s_r.pulseLeft == {$past(s_r.pulseCfg), 1'b0});
   endproperty
   a_pulseLen: assert property (p_pulseLen)
      else $error("pulse length not twice setting");

   property p_holdEq;
      (s_r.pulseOn && s_r.pulseHold) |-> (s_r.cnt == s_r.cmpVal);
   endproperty
   a_holdEq: assert property (p_holdEq)
      else $error("held pulse outside comparison");

   property p_noRetrig;
      (clkEn && s_r.pulseOn && !s_r.pulseHold && s_r.outChar == OC_PULSE
       && !wrEn && s_r.msDiv < MS_TOP)
         |=> $stable(s_r.pulseLeft);
   endproperty
   a_noRetrig: assert property (p_noRetrig)
      else $error("pulse retriggered");

   property p_filter;
      (clkEn && $rose(s_r.lvl[0])) |-> $past(cntPulse[0]);
   endproperty
   a_filter: assert property (p_filter)
      else $error("filtered level without input");

   property p_gateIrq;
      (procIrq && (irqCause[EV_GOPEN] || irqCause[EV_GCLOSE]))
         |-> $past(s_r.swGate && s_r.hwGateEn);
   endproperty
   a_gateIrq: assert property (p_gateIrq)
      else $error("gate interrupt with closed gate");

   property p_maskOff;
      (clkEn && s_r.irqEn == 6'h00) |=> !procIrq;
   endproperty
   a_maskOff: assert property (p_maskOff)
      else $error("interrupt while all disabled");

   property p_selNone;
      (clkEn && s_r.irqSel == IS_NONE) |=> (!procIrq && !diagIrq);
   endproperty
   a_selNone: assert property (p_selNone)
      else $error("interrupt with select none");

   property p_integRange;
      (s_r.integCfg >= INTEG_MIN) && (s_r.integCfg <= INTEG_MAX);
   endproperty
   a_integRange: assert property (p_integRange)
      else $error("integration time out of range");

   property p_chRead;
      (rdEn && addr == ADDR_CH0 && s_r.freqMode)
         |=> (rdData == $past(s_r.freqVal[0]));
   endproperty
   a_chRead: assert property (p_chRead)
      else $error("channel read value wrong");

   c_pulse: cover property (s_r.outChar == OC_PULSE ##1 $rose(chanOut));
   c_meas: cover property (procIrq && irqCause[EV_MEAS]);
   c_diag: cover property (diagIrq);
   c_ovf: cover property (procIrq && irqCause[EV_OVF]);
endmodule : ccfm_top

// File: verification/ccfm_field.sv
// Pulse source, gate driver and actuator monitor at the channel pins
`timescale 1ns/1ps
module ccfm_field (
   input  wire logic       clk_sys,
   input  wire logic       chanOut,
   output logic      [3:0] cntPulse,
   output logic            cntDir,
   output logic            extGateIn,
   output int              onLen
);
   int run = 0;

   initial begin
      cntPulse  = 4'h0;
      cntDir    = 1'b1;
      extGateIn = 1'b0;
      onLen     = 0;
   end

   ////////////////////////////////////////
   // Edges held four clocks: pass the 60 kHz filter, fail the 1 kHz one
   task automatic pulses(input int ch, input int n, input logic up);
      @(posedge clk_sys);
      cntDir <= up;
      repeat (4) @(posedge clk_sys);
      repeat (n) begin
         @(posedge clk_sys);
         cntPulse[ch] <= 1'b1;
         repeat (4) @(posedge clk_sys);
         cntPulse[ch] <= 1'b0;
         repeat (4) @(posedge clk_sys);
      end
   endtask : pulses

   task automatic gate(input logic v);
      @(posedge clk_sys);
      extGateIn <= v;
      repeat (3) @(posedge clk_sys);
   endtask : gate

   ////////////////////////////////////////
   // Actuator side: length of the last high phase of the output
   always @(posedge clk_sys) begin
      if (chanOut === 1'b1) begin
         run <= run + 1;
      end
      else begin
         if (run != 0) onLen <= run;
         run <= 0;
      end
   end
endmodule : ccfm_field

// File: verification/tb_top.sv
// Self-checking bench for the counter, compare and frequency block
`timescale 1ns/1ps
module tb_top;
   import ccfm_pkg::*;
   // One millisecond is 100 clocks at this rate
   localparam int SIM_HZ = 100_000;
   typedef struct packed {logic wr; logic [11:0] a; logic [31:0] d;} ccfm_row_t;
   localparam ccfm_row_t ROWS [19] = '{
      '{1'b0, ADDR_CTRL, 32'h500}, '{1'b0, ADDR_IRQEN, 32'h0},
      '{1'b0, ADDR_CMPVAL, 32'h0}, '{1'b0, ADDR_PULSE, 32'h0},
      '{1'b0, ADDR_INTEG, 32'h64}, '{1'b0, ADDR_STATUS, 32'h0},
      '{1'b0, ADDR_CH0, 32'h0}, '{1'b0, ADDR_CH1, 32'h0},
      '{1'b0, ADDR_CH2, 32'h0}, '{1'b0, ADDR_CH3, 32'h0},
      '{1'b0, 12'h320, 32'h0}, '{1'b1, ADDR_INTEG, 32'h5},
      '{1'b0, ADDR_INTEG, 32'ha}, '{1'b1, ADDR_INTEG, 32'h4e20},
      '{1'b0, ADDR_INTEG, 32'h2710}, '{1'b1, ADDR_PULSE, 32'hff},
      '{1'b0, ADDR_PULSE, 32'hff}, '{1'b1, ADDR_CH0, 32'h55},
      '{1'b0, ADDR_CH0, 32'h0}};

   logic        clk_sys = 1'b0;
   logic        nrst    = 1'b0;
   logic        clkEn   = 1'b1;
   logic [11:0] addr    = 12'h000;
   logic [31:0] wrData  = 32'h0;
   logic        wrEn    = 1'b0;
   logic        rdEn    = 1'b0;
   logic [31:0] rdData;
   logic [3:0]  cntPulse;
   logic        cntDir, extGateIn, chanOut, cmpStatusFlag, procIrq, diagIrq;
   logic [5:0]  irqCause;
   int          onLen, n0, d0;
   int          num_errors = 0, n_compared = 0;
   int          irqCnt = 0, diagCnt = 0, cycles = 0;
   logic [31:0] v;

   ccfm_top #(.CLK_HZ(SIM_HZ)) i_dut (.clk_sys(clk_sys), .nrst(nrst),
      .clkEn(clkEn), .addr(addr), .wrData(wrData), .wrEn(wrEn),
      .rdEn(rdEn), .rdData(rdData), .cntPulse(cntPulse), .cntDir(cntDir),
      .extGateIn(extGateIn), .chanOut(chanOut),
      .cmpStatusFlag(cmpStatusFlag), .procIrq(procIrq),
      .diagIrq(diagIrq), .irqCause(irqCause));
   ccfm_field i_fld (.clk_sys(clk_sys), .chanOut(chanOut),
      .cntPulse(cntPulse), .cntDir(cntDir), .extGateIn(extGateIn),
      .onLen(onLen));

   always #20 clk_sys = ~clk_sys;

   ////////////////////////////////////////
   task automatic finish_test;
      $display("Compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Test passed");
      end
      else begin
         $display("Test failed");
      end
      $finish;
   endtask : finish_test

   // Interrupt pulses last one cycle, so they are counted here
   always @(posedge clk_sys) begin
      cycles++;
      if (procIrq === 1'b1) irqCnt++;
      if (diagIrq === 1'b1) diagCnt++;
      if (cycles == 30000) begin
         num_errors++;
         finish_test();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      wrEn   <= 1'b1;
      addr   <= a;
      wrData <= d;
      @(posedge clk_sys);
      wrEn <= 1'b0;
   endtask : wr

   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      rdEn <= 1'b1;
      addr <= a;
      @(posedge clk_sys);
      rdEn <= 1'b0;
      #1 d = rdData;
   endtask : rd

   task automatic waitCyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : waitCyc

   // Measurement windows may be long before the first short one starts
   task automatic waitIrq(input int k0);
      for (int k = 0; k < 12000 && irqCnt == k0; k++) @(posedge clk_sys);
      #1;
      chk(32'(irqCnt - k0), 32'h1);
   endtask : waitIrq

   task automatic waitLow;
      for (int k = 0; k < 600 && chanOut !== 1'b0; k++) @(posedge clk_sys);
      #1;
   endtask : waitLow

   ////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (4) @(posedge clk_sys);
      foreach (ROWS[i]) begin
         if (ROWS[i].wr) begin
            wr(ROWS[i].a, ROWS[i].d);
         end
         else begin
            rd(ROWS[i].a, v);
            chk(v, ROWS[i].d);
         end
      end
      // Comparator, greater or equal, then less or equal
      wr(ADDR_CMPVAL, 32'h3);
      wr(ADDR_IRQEN, 32'h4);
      wr(ADDR_CTRL, 32'hd09);
      i_fld.pulses(3, 2, 1'b1);
      waitCyc(3);
      chk(32'({chanOut, cmpStatusFlag}), 32'h0);
      n0 = irqCnt;
      i_fld.pulses(3, 1, 1'b1);
      waitCyc(3);
      chk(32'({chanOut, cmpStatusFlag}), 32'h3);
      chk(32'(irqCnt - n0), 32'h1);
      chk(32'(irqCause), 32'h4);
      rd(ADDR_CH3, v);
      chk(v, 32'h3);
      // Frozen clock enable, then a pulse too short for the 1 kHz filter
      @(posedge clk_sys);
      clkEn <= 1'b0;
      i_fld.pulses(3, 1, 1'b1);
      clkEn <= 1'b1;
      rd(ADDR_CH3, v);
      chk(v, 32'h3);
      wr(ADDR_CTRL, 32'h9);
      i_fld.pulses(3, 1, 1'b1);
      rd(ADDR_CH3, v);
      chk(v, 32'h3);
      wr(ADDR_CTRL, 32'hd11);
      waitCyc(3);
      chk(32'(chanOut), 32'h1);
      i_fld.pulses(3, 1, 1'b1);
      waitCyc(3);
      chk(32'({chanOut, cmpStatusFlag}), 32'h0);
      // No comparison: plain software output
      wr(ADDR_CTRL, 32'hd81);
      waitCyc(3);
      chk(32'({chanOut, cmpStatusFlag}), 32'h2);
      wr(ADDR_CTRL, 32'hd01);
      waitCyc(3);
      chk(32'(chanOut), 32'h0);
      // Pulse mode, counter stands at 4
      wr(ADDR_PULSE, 32'h1);
      wr(ADDR_CMPVAL, 32'h5);
      wr(ADDR_CTRL, 32'h519);
      i_fld.pulses(3, 1, 1'b1);
      wr(ADDR_PULSE, 32'h2);
      i_fld.pulses(3, 1, 1'b0);
      i_fld.pulses(3, 1, 1'b1);
      waitLow();
      chk(32'(onLen >= 100 && onLen <= 201), 32'h1);
      i_fld.pulses(3, 1, 1'b0);
      i_fld.pulses(3, 1, 1'b1);
      waitLow();
      chk(32'(onLen >= 300 && onLen <= 401), 32'h1);
      // Main direction up: reaching from above gives nothing
      wr(ADDR_CTRL, 32'h539);
      i_fld.pulses(3, 1, 1'b1);
      i_fld.pulses(3, 1, 1'b0);
      waitCyc(3);
      chk(32'(chanOut), 32'h0);
      i_fld.pulses(3, 1, 1'b0);
      i_fld.pulses(3, 1, 1'b1);
      waitCyc(2);
      chk(32'(chanOut), 32'h1);
      waitLow();
      // Zero duration holds while the counter sits on the value
      wr(ADDR_PULSE, 32'h0);
      wr(ADDR_CTRL, 32'h519);
      i_fld.pulses(3, 1, 1'b0);
      i_fld.pulses(3, 1, 1'b1);
      waitCyc(300);
      chk(32'(chanOut), 32'h1);
      i_fld.pulses(3, 1, 1'b1);
      waitCyc(3);
      chk(32'(chanOut), 32'h0);
      // Gate edges, lost interrupt, gate blocks counting
      wr(ADDR_ACK, 32'h1);
      wr(ADDR_IRQEN, 32'h3);
      wr(ADDR_CTRL, 32'h1503);
      n0 = irqCnt;
      d0 = diagCnt;
      i_fld.gate(1'b1);
      waitCyc(3);
      chk(32'(irqCnt - n0), 32'h1);
      chk(32'(irqCause), 32'h1);
      i_fld.gate(1'b0);
      waitCyc(3);
      chk(32'(irqCnt - n0), 32'h2);
      chk(32'(irqCause), 32'h2);
      chk(32'(diagCnt - d0), 32'h1);
      i_fld.pulses(3, 1, 1'b1);
      rd(ADDR_CH3, v);
      chk(v, 32'h6);
      wr(ADDR_CTRL, 32'h1502);
      i_fld.gate(1'b1);
      i_fld.gate(1'b0);
      waitCyc(3);
      chk(32'(irqCnt - n0), 32'h2);
      // Frequency measurement over 10 ms windows
      wr(ADDR_INTEG, 32'ha);
      wr(ADDR_IRQEN, 32'h20);
      wr(ADDR_CTRL, 32'hd05);
      waitIrq(irqCnt);
      n0 = irqCnt;
      i_fld.pulses(1, 5, 1'b1);
      i_fld.pulses(2, 3, 1'b1);
      waitIrq(n0);
      chk(32'(irqCause), 32'h20);
      rd(ADDR_CH1, v);
      chk(v, 32'h5);
      rd(ADDR_CH2, v);
      chk(v, 32'h3);
      rd(ADDR_CH0, v);
      chk(v, 32'h0);
      finish_test();
   end
endmodule : tb_top
